// File: hdl/cbo_exec.sv
// Execution unit for compare-branch, clear, complement, decimal adjust, decrement, divide
`timescale 1ns/1ps
`include "cbo_defs.svh"
module cbo_exec (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Instruction from decoder and architectural snapshot
	input cbo_pkg::cbo_issue_t issue,
	input cbo_pkg::cbo_arch_t arch_in,
	// Read data for byte and bit operands
	input wire logic [7:0] mem_rdata,
	input wire logic bit_rdata,
	// Requests and results
	output logic busy,
	output cbo_pkg::cbo_mem_t mem_req,
	output cbo_pkg::cbo_bit_t bit_req,
	output cbo_pkg::cbo_res_t res
);
	cbo_pkg::cbo_s_t s_q;
	cbo_pkg::cbo_s_t s_d;
	logic accept;
	logic [7:0] dv_rem [0:`CBO_DIV_STEPS];
	logic [7:0] dv_quo [0:`CBO_DIV_STEPS];

	////////////////////////////////////////////////////////////////////////
	// Divider: two steps per cycle
	assign dv_rem[0] = s_q.rem;
	assign dv_quo[0] = s_q.quo;
	for (genvar g = 0; g < `CBO_DIV_STEPS; g++) begin : g_div
		logic q;
		cbo_div_step u_step (
			.rem_in(dv_rem[g]),
			.dvd_bit(dv_quo[g][7]),
			.divisor(s_q.arch.b),
			.rem_out(dv_rem[g+1]),
			.q_out(q)
		);
		assign dv_quo[g+1] = {dv_quo[g][6:0], q};
	end

	assign accept = (s_q.st == cbo_pkg::ST_IDLE) && issue.valid;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [7:0] opnd;
		logic bitv;
		logic [7:0] cmp_a;
		logic [7:0] cmp_b;
		logic [8:0] adj_t;
		logic adj_c;
		logic [2:0] cyc;
		opnd = s_q.first ? mem_rdata : s_q.opnd;
		bitv = s_q.first ? bit_rdata : s_q.bitv;
		cmp_a = (s_q.op == cbo_pkg::OP_CMPBR_MEM) ? opnd : s_q.arch.acc;
		cmp_b = (s_q.op == cbo_pkg::OP_CMPBR_DIR) ? opnd : s_q.byte2;
		adj_t = {1'b0, s_q.arch.acc};
		adj_c = s_q.arch.carry;
		cyc = `CBO_CYC_ONE;
		if (s_q.arch.acc[3:0] > `CBO_BCD_MAX || s_q.arch.aux) begin
			adj_t = adj_t + {5'h00, `CBO_BCD_FIX};
		end
		adj_c = adj_c | adj_t[8];
		if (adj_t[7:4] > `CBO_BCD_MAX || adj_c) begin
			adj_t = {1'b0, adj_t[7:0]} + {1'b0, `CBO_BCD_FIX, 4'h0};
		end
		adj_c = adj_c | adj_t[8];
		s_d = s_q;
		s_d.res.done = 1'b0;
		s_d.res.acc_we = 1'b0;
		s_d.res.b_we = 1'b0;
		s_d.res.c_we = 1'b0;
		s_d.res.overflow_we = 1'b0;
		s_d.res.pc_we = 1'b0;
		s_d.mem.rd = 1'b0;
		s_d.mem.wr = 1'b0;
		s_d.bitq.rd = 1'b0;
		s_d.bitq.wr = 1'b0;
		case (s_q.st)
			cbo_pkg::ST_IDLE: begin
				if (issue.valid) begin
					s_d.st = cbo_pkg::ST_EXEC;
					s_d.busy = 1'b1;
					s_d.first = 1'b1;
					s_d.arch = arch_in;
					s_d.byte2 = issue.byte2;
					s_d.byte3 = issue.byte3;
					s_d.pc = issue.pc + `CBO_PC_STEP;
					s_d.rem = 8'h00;
					s_d.quo = arch_in.acc;
					s_d.mem.reg_idx = issue.opcode[2:0];
					s_d.mem.ptr_idx = issue.opcode[0];
					s_d.mem.addr = issue.byte2;
					s_d.mem.latch = 1'b0;
					s_d.bitq.addr = issue.byte2;
					s_d.bitq.latch = 1'b1;
					s_d.op = cbo_pkg::OP_NONE;
					if (issue.opcode == `CBO_OPC_CMPBR_IMM) begin
						s_d.op = cbo_pkg::OP_CMPBR_IMM;
						cyc = `CBO_CYC_TWO;
					end else if (issue.opcode == `CBO_OPC_CMPBR_DIR) begin
						s_d.op = cbo_pkg::OP_CMPBR_DIR;
						s_d.mem.kind = cbo_pkg::MK_DIRECT;
						s_d.mem.rd = 1'b1;
						cyc = `CBO_CYC_TWO;
					end else if (issue.opcode[7:1] == `CBO_OPC_CMPBR_IND) begin
						s_d.op = cbo_pkg::OP_CMPBR_MEM;
						s_d.mem.kind = cbo_pkg::MK_INDIRECT;
						s_d.mem.rd = 1'b1;
						cyc = `CBO_CYC_TWO;
					end else if (issue.opcode[7:3] == `CBO_OPC_CMPBR_REG) begin
						s_d.op = cbo_pkg::OP_CMPBR_MEM;
						s_d.mem.kind = cbo_pkg::MK_REG;
						s_d.mem.rd = 1'b1;
						cyc = `CBO_CYC_TWO;
					end else if (issue.opcode == `CBO_OPC_CLEAR_A) begin
						s_d.op = cbo_pkg::OP_CLEAR_A;
					end else if (issue.opcode == `CBO_OPC_CLEAR_C) begin
						s_d.op = cbo_pkg::OP_CLEAR_C;
					end else if (issue.opcode == `CBO_OPC_CLEAR_BIT) begin
						s_d.op = cbo_pkg::OP_CLEAR_BIT;
					end else if (issue.opcode == `CBO_OPC_COMPL_A) begin
						s_d.op = cbo_pkg::OP_COMPL_A;
					end else if (issue.opcode == `CBO_OPC_COMPL_C) begin
						s_d.op = cbo_pkg::OP_COMPL_C;
					end else if (issue.opcode == `CBO_OPC_COMPL_BIT) begin
						s_d.op = cbo_pkg::OP_COMPL_BIT;
						s_d.bitq.rd = 1'b1;
					end else if (issue.opcode == `CBO_OPC_DECADJ) begin
						s_d.op = cbo_pkg::OP_DECADJ;
					end else if (issue.opcode == `CBO_OPC_DECR_A) begin
						s_d.op = cbo_pkg::OP_DECR_A;
					end else if (issue.opcode == `CBO_OPC_DECR_DIR) begin
						s_d.op = cbo_pkg::OP_DECR_MEM;
						s_d.mem.kind = cbo_pkg::MK_DIRECT;
						s_d.mem.rd = 1'b1;
						s_d.mem.latch = 1'b1;
					end else if (issue.opcode[7:1] == `CBO_OPC_DECR_IND) begin
						s_d.op = cbo_pkg::OP_DECR_MEM;
						s_d.mem.kind = cbo_pkg::MK_INDIRECT;
						s_d.mem.rd = 1'b1;
						s_d.mem.latch = 1'b1;
					end else if (issue.opcode[7:3] == `CBO_OPC_DECR_REG) begin
						s_d.op = cbo_pkg::OP_DECR_MEM;
						s_d.mem.kind = cbo_pkg::MK_REG;
						s_d.mem.rd = 1'b1;
						s_d.mem.latch = 1'b1;
					end else if (issue.opcode == `CBO_OPC_DIV) begin
						s_d.op = cbo_pkg::OP_DIV;
						cyc = `CBO_CYC_FOUR;
					end
					s_d.cnt = cyc - `CBO_CYC_ONE;
				end
			end
			cbo_pkg::ST_EXEC: begin
				s_d.first = 1'b0;
				s_d.opnd = opnd;
				s_d.bitv = bitv;
				s_d.rem = dv_rem[`CBO_DIV_STEPS];
				s_d.quo = dv_quo[`CBO_DIV_STEPS];
				if (s_q.cnt != 3'h0) begin
					s_d.cnt = s_q.cnt - 3'h1;
				end else begin
					s_d.st = cbo_pkg::ST_IDLE;
					s_d.busy = 1'b0;
					s_d.res.done = 1'b1;
					case (s_q.op)
						cbo_pkg::OP_CMPBR_IMM, cbo_pkg::OP_CMPBR_DIR, cbo_pkg::OP_CMPBR_MEM: begin
							s_d.res.c_we = 1'b1;
							s_d.res.c = cmp_a < cmp_b;
							s_d.res.pc_we = 1'b1;
							s_d.res.pc = s_q.pc;
							if (cmp_a != cmp_b) begin
								s_d.res.pc = s_q.pc + {{8{s_q.byte3[7]}}, s_q.byte3};
							end
						end
						cbo_pkg::OP_CLEAR_A: begin
							s_d.res.acc_we = 1'b1;
							s_d.res.acc = 8'h00;
						end
						cbo_pkg::OP_CLEAR_C, cbo_pkg::OP_COMPL_C: begin
							s_d.res.c_we = 1'b1;
							s_d.res.c = (s_q.op == cbo_pkg::OP_COMPL_C) & ~s_q.arch.carry;
						end
						cbo_pkg::OP_CLEAR_BIT, cbo_pkg::OP_COMPL_BIT: begin
							s_d.bitq.wr = 1'b1;
							s_d.bitq.wdata = (s_q.op == cbo_pkg::OP_COMPL_BIT) & ~bitv;
						end
						cbo_pkg::OP_COMPL_A: begin
							s_d.res.acc_we = 1'b1;
							s_d.res.acc = ~s_q.arch.acc;
						end
						cbo_pkg::OP_DECADJ: begin
							s_d.res.acc_we = 1'b1;
							s_d.res.acc = adj_t[7:0];
							s_d.res.c_we = 1'b1;
							s_d.res.c = adj_c;
						end
						cbo_pkg::OP_DECR_A: begin
							s_d.res.acc_we = 1'b1;
							s_d.res.acc = s_q.arch.acc - 8'h01;
						end
						cbo_pkg::OP_DECR_MEM: begin
							s_d.mem.wr = 1'b1;
							s_d.mem.wdata = opnd - 8'h01;
						end
						cbo_pkg::OP_DIV: begin
							s_d.res.c_we = 1'b1;
							s_d.res.c = 1'b0;
							s_d.res.overflow_we = 1'b1;
							s_d.res.overflow_flag = s_q.arch.b == 8'h00;
							if (s_q.arch.b != 8'h00) begin
								s_d.res.acc_we = 1'b1;
								s_d.res.acc = dv_quo[`CBO_DIV_STEPS];
								s_d.res.b_we = 1'b1;
								s_d.res.b = dv_rem[`CBO_DIV_STEPS];
							end
						end
						default: begin
						end
					endcase
				end
			end
			default: begin
				s_d.st = cbo_pkg::ST_IDLE;
				s_d.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.st <= cbo_pkg::ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = s_q.busy;
	assign mem_req = s_q.mem;
	assign bit_req = s_q.bitq;
	assign res = s_q.res;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_cmpbr_timing: assert property (accept && s_d.op inside {cbo_pkg::OP_CMPBR_IMM,
		cbo_pkg::OP_CMPBR_DIR, cbo_pkg::OP_CMPBR_MEM} |-> ##1 !res.done ##1 !res.done
		##1 res.done) else $error("compare branch timing wrong");
	a_pc_step: assert property (accept |=> s_q.pc == $past(issue.pc) + 16'h0003)
		else $error("pc not advanced by three");
	a_cmpbr_carry: assert property (res.done && res.pc_we |-> res.c ==
		((s_q.op == cbo_pkg::OP_CMPBR_MEM ? s_q.opnd : s_q.arch.acc) <
		(s_q.op == cbo_pkg::OP_CMPBR_DIR ? s_q.opnd : s_q.byte2))) else $error("compare carry wrong");
	a_cmpbr_target: assert property (res.done && res.pc_we |-> res.pc == s_q.pc +
		(((s_q.op == cbo_pkg::OP_CMPBR_MEM ? s_q.opnd : s_q.arch.acc) !=
		(s_q.op == cbo_pkg::OP_CMPBR_DIR ? s_q.opnd : s_q.byte2)) ?
		{{8{s_q.byte3[7]}}, s_q.byte3} : 16'h0000)) else $error("branch target wrong");
	a_clear_acc: assert property (res.done && s_q.op == cbo_pkg::OP_CLEAR_A |->
		res.acc_we && res.acc == 8'h00 && !res.c_we && !res.overflow_we)
		else $error("clear acc wrong");
	a_clear_bit: assert property (res.done && s_q.op == cbo_pkg::OP_CLEAR_BIT |->
		bit_req.wr && !bit_req.wdata && !res.c_we) else $error("clear bit wrong");
	a_compl_acc: assert property (accept && issue.opcode == 8'hF4 |-> ##2 res.done &&
		res.acc == ~$past(arch_in.acc, 2) && !res.c_we) else $error("complement acc wrong");
	a_bit_latch: assert property (bit_req.rd |-> bit_req.latch ##1 bit_req.wr
		&& bit_req.wdata == ~$past(bit_rdata)) else $error("bit complement source wrong");
	a_adjust_carry: assert property (res.done && s_q.op == cbo_pkg::OP_DECADJ |->
		res.c_we && (res.c || !s_q.arch.carry) && !res.overflow_we)
		else $error("adjust cleared carry");
	a_decr_wrap: assert property (mem_req.rd && mem_req.latch |=> mem_req.wr &&
		mem_req.wdata == $past(mem_rdata) - 8'h01 && !res.c_we) else $error("decrement wrong");
	a_div_four: assert property (accept && issue.opcode == 8'h84 |-> ##5 res.done &&
		res.overflow_we) else $error("divide timing wrong");
	a_div_result: assert property (res.done && s_q.op == cbo_pkg::OP_DIV && s_q.arch.b != 8'h00
		|-> !res.c && !res.overflow_flag && res.b < s_q.arch.b && {8'h00, s_q.arch.acc} ==
		16'({8'h00, res.acc} * {8'h00, s_q.arch.b}) + {8'h00, res.b}) else $error("divide wrong");
	a_div_zero: assert property (res.done && s_q.op == cbo_pkg::OP_DIV && s_q.arch.b == 8'h00
		|-> res.overflow_flag && !res.c) else $error("zero divisor flags wrong");
	a_reg_sel: assert property (accept |=> mem_req.reg_idx == $past(issue.opcode[2:0]) &&
		mem_req.ptr_idx == $past(issue.opcode[0])) else $error("register select wrong");

	c_branch: cover property (res.done && res.pc_we && res.pc != s_q.pc);
	c_div_zero: cover property (res.done && s_q.op == cbo_pkg::OP_DIV && res.overflow_flag);
	c_adjust_carry: cover property (res.done && s_q.op == cbo_pkg::OP_DECADJ && res.c &&
		!s_q.arch.carry);
	c_decr_mem: cover property (mem_req.wr);
endmodule

// File: hdl/cbo_defs.svh
// Opcodes, cycle counts and constants of the compare, clear, adjust and divide unit
`ifndef CBO_DEFS_SVH
`define CBO_DEFS_SVH
// Notes on behaviour
// - Compare-branch: three bytes, two cycles, pc plus three
// - Compare sets carry when first below second
// - Unequal compare branches by signed displacement
// - Aux carry is bit-3 carry, carry bit 7
// - Clear accumulator to zero, flags untouched
// - Clear carry or addressable bit, nothing else
// - Complement accumulator, one cycle, no flags
// - Complement carry or addressable bit, nothing else
// - Port read-modify-write uses output latch value
// - Low nibble over nine or aux: add six
// - Then carry or high over nine: add sixty
// - Adjust only sets carry, overflow left alone
// - Whole decimal adjust takes one cycle
// - Decrement wraps zero to all ones, no flags
// - Decrement accumulator, register, direct or indirect byte
// - Divide accumulator by B over four cycles
// - Normal divide clears carry and overflow
// - Zero divisor sets overflow, clears carry
`define CBO_OPC_CMPBR_IMM 8'hB4
`define CBO_OPC_CMPBR_DIR 8'hB5
`define CBO_OPC_CMPBR_IND 7'h5B
`define CBO_OPC_CMPBR_REG 5'h17
`define CBO_OPC_CLEAR_A 8'hE4
`define CBO_OPC_CLEAR_C 8'hC3
`define CBO_OPC_CLEAR_BIT 8'hC2
`define CBO_OPC_COMPL_A 8'hF4
`define CBO_OPC_COMPL_C 8'hB3
`define CBO_OPC_COMPL_BIT 8'hB2
`define CBO_OPC_DECADJ 8'hD4
`define CBO_OPC_DECR_A 8'h14
`define CBO_OPC_DECR_DIR 8'h15
`define CBO_OPC_DECR_IND 7'h0B
`define CBO_OPC_DECR_REG 5'h03
`define CBO_OPC_DIV 8'h84
`define CBO_CYC_ONE 3'h1
`define CBO_CYC_TWO 3'h2
`define CBO_CYC_FOUR 3'h4
`define CBO_PC_STEP 16'h0003
`define CBO_BCD_MAX 4'h9
`define CBO_BCD_FIX 4'h6
`define CBO_DIV_STEPS 2
`endif

// File: hdl/cbo_pkg.sv
// Types of the compare, clear, adjust and divide unit
package cbo_pkg;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} cbo_state_t;
	typedef enum logic [3:0] {
		OP_NONE, OP_CMPBR_IMM, OP_CMPBR_DIR, OP_CMPBR_MEM, OP_CLEAR_A, OP_CLEAR_C,
		OP_CLEAR_BIT, OP_COMPL_A, OP_COMPL_C, OP_COMPL_BIT, OP_DECADJ, OP_DECR_A,
		OP_DECR_MEM, OP_DIV
	} cbo_op_t;
	typedef enum logic [1:0] {MK_REG, MK_DIRECT, MK_INDIRECT} cbo_mkind_t;
	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
		logic [7:0] byte2;
		logic [7:0] byte3;
		logic [15:0] pc;
	} cbo_issue_t;
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] b;
		logic carry;
		logic aux;
		logic overflow_flag;
	} cbo_arch_t;
	typedef struct packed {
		logic rd;
		logic wr;
		cbo_mkind_t kind;
		logic [2:0] reg_idx;
		logic ptr_idx;
		logic [7:0] addr;
		logic latch;
		logic [7:0] wdata;
	} cbo_mem_t;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic latch;
		logic wdata;
	} cbo_bit_t;
	typedef struct packed {
		logic done;
		logic acc_we;
		logic [7:0] acc;
		logic b_we;
		logic [7:0] b;
		logic c_we;
		logic c;
		logic overflow_we;
		logic overflow_flag;
		logic pc_we;
		logic [15:0] pc;
	} cbo_res_t;
	typedef struct packed {
		cbo_state_t st;
		cbo_op_t op;
		logic [2:0] cnt;
		logic first;
		logic busy;
		cbo_arch_t arch;
		logic [7:0] byte2;
		logic [7:0] byte3;
		logic [15:0] pc;
		logic [7:0] opnd;
		logic bitv;
		logic [7:0] rem;
		logic [7:0] quo;
		cbo_mem_t mem;
		cbo_bit_t bitq;
		cbo_res_t res;
	} cbo_s_t;
endpackage

// File: hdl/cbo_div_step.sv
// One restoring division step
`timescale 1ns/1ps
module cbo_div_step (
	// Partial remainder and next dividend bit
	input wire logic [7:0] rem_in,
	input wire logic dvd_bit,
	input wire logic [7:0] divisor,
	// Step result
	output logic [7:0] rem_out,
	output logic q_out
);
	logic [8:0] part;
	logic [9:0] diff;
	assign part = {rem_in, dvd_bit};
	assign diff = {1'b0, part} - {2'h0, divisor};
	assign q_out = ~diff[9];
	assign rem_out = q_out ? diff[7:0] : part[7:0];
endmodule

// File: sim/cbo_exec_tb.sv
// Self-checking bench for the compare, clear, adjust and divide unit
`timescale 1ns/1ps
module compare_clear_bcd_div_ops_tb_top;
	logic core_clk;
	logic rst_n;
	cbo_pkg::cbo_issue_t issue;
	cbo_pkg::cbo_arch_t arch_in;
	logic [7:0] mem_rdata;
	logic bit_rdata;
	logic busy;
	cbo_pkg::cbo_mem_t mem_req;
	cbo_pkg::cbo_bit_t bit_req;
	cbo_pkg::cbo_res_t res;
	cbo_pkg::cbo_res_t r;
	cbo_pkg::cbo_mem_t mr;
	cbo_pkg::cbo_mem_t mw;
	cbo_pkg::cbo_bit_t br;
	cbo_pkg::cbo_bit_t bw;
	logic mrd;
	logic brd;
	logic [7:0] bb;
	logic [7:0] b3;
	int failures;
	int n_checks;
	int cyc;

	cbo_exec u_dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.issue(issue),
		.arch_in(arch_in),
		.mem_rdata(mem_rdata),
		.bit_rdata(bit_rdata),
		.busy(busy),
		.mem_req(mem_req),
		.bit_req(bit_req),
		.res(res)
	);

	////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Issue one instruction, answer reads in cycle 1 only, capture results
	task automatic run(input logic [7:0] op, b2, a, m, input logic c, aux_in, input int n);
		@(posedge core_clk);
		issue <= '{1'h1, op, b2, b3, 16'h0100};
		arch_in <= '{a, bb, c, aux_in, 1'h1};
		mem_rdata <= ~m;
		bit_rdata <= ~m[0];
		mrd = 1'h0;
		brd = 1'h0;
		cyc = 0;
		@(posedge core_clk);
		issue.valid <= 1'h0;
		mem_rdata <= m;
		bit_rdata <= m[0];
		#1;
		while (res.done !== 1'h1 && cyc < 9) begin
			chk(busy, 1'h1);
			if (mem_req.rd === 1'h1) begin
				mrd = 1'h1;
				mr = mem_req;
			end
			if (bit_req.rd === 1'h1) begin
				brd = 1'h1;
				br = bit_req;
			end
			@(posedge core_clk);
			mem_rdata <= ~m;
			bit_rdata <= ~m[0];
			#1;
			cyc++;
		end
		r = res;
		mw = mem_req;
		bw = bit_req;
		chk(cyc, n);
		chk(busy, 1'h0);
	endtask

	////////////////////////////////////////////////
	task automatic t_compare;
		logic [7:0] ops[4] = '{8'hB4, 8'hB5, 8'hB7, 8'hBD};
		logic [7:0] y;
		cbo_pkg::cbo_mkind_t kd;
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 3; k++) begin
				y = 8'h4F + 8'(k);
				b3 = k == 0 ? 8'hF0 : 8'h20;
				kd = i == 1 ? cbo_pkg::MK_DIRECT : (i == 2 ? cbo_pkg::MK_INDIRECT : cbo_pkg::MK_REG);
				run(ops[i], y, i < 2 ? 8'h50 : 8'h00, i == 1 ? y : 8'h50, k != 2, 1'h0, 2);
				chk({r.c_we, r.c}, {1'h1, k == 2});
				chk({r.pc_we, r.pc}, {1'h1, 16'h0103 + (k == 1 ? 16'h0 : {{8{b3[7]}}, b3})});
				chk({r.acc_we, r.b_we, r.overflow_we, mw.wr}, 0);
				if (i > 0) begin
					chk({mrd, mr.latch, mr.kind, mr.reg_idx}, {2'h2, kd, ops[i][2:0]});
					chk(mr.ptr_idx, ops[i][0]);
				end
			end
		end
	endtask

	task automatic t_clear_compl;
		run(8'hE4, 8'h00, 8'h5C, 8'h00, 1'h1, 1'h1, 1);
		chk({r.acc_we, r.acc, r.c_we, r.overflow_we}, {1'h1, 8'h00, 2'h0});
		run(8'hF4, 8'h00, 8'h5C, 8'h00, 1'h1, 1'h1, 1);
		chk({r.acc_we, r.acc, r.c_we, r.overflow_we}, {1'h1, 8'hA3, 2'h0});
		for (int k = 0; k < 2; k++) begin
			run(8'hC3, 8'h00, 8'h5C, 8'h00, k[0], 1'h0, 1);
			chk({r.c_we, r.c, r.acc_we, r.overflow_we}, 4'h8);
			run(8'hB3, 8'h00, 8'h5C, 8'h00, k[0], 1'h0, 1);
			chk({r.c_we, r.c, r.acc_we, r.overflow_we}, {1'h1, !k[0], 2'h0});
			run(8'hB2, 8'h91, 8'h5C, {7'h0, k[0]}, 1'h0, 1'h0, 1);
			chk({brd, br.latch, br.addr, bw.wr, bw.wdata}, {2'h3, 8'h91, 1'h1, !k[0]});
			chk({r.c_we, r.overflow_we, r.acc_we}, 0);
			run(8'hC2, 8'h92, 8'h5C, {7'h0, k[0]}, 1'h1, 1'h0, 1);
			chk({bw.wr, bw.addr, bw.wdata, r.c_we, r.overflow_we}, {1'h1, 8'h92, 3'h0});
		end
	endtask

	task automatic t_adjust;
		logic [7:0] ai[6] = '{8'hBE, 8'hC9, 8'h19, 8'h12, 8'hFA, 8'h56};
		logic [7:0] ao[6] = '{8'h24, 8'h29, 8'h1F, 8'h72, 8'h60, 8'h56};
		logic [5:0] ci = 6'h08;
		logic [5:0] ax = 6'h04;
		logic [5:0] co = 6'h1B;
		for (int i = 0; i < 6; i++) begin
			run(8'hD4, 8'h00, ai[i], 8'h00, ci[i], ax[i], 1);
			chk(r.acc_we ? r.acc : ai[i], ao[i]);
			chk({r.c_we ? r.c : ci[i], r.overflow_we}, {co[i], 1'h0});
		end
	endtask

	task automatic t_decr;
		logic [7:0] ops[3] = '{8'h15, 8'h1B, 8'h17};
		logic [7:0] mv[3] = '{8'h5D, 8'h00, 8'h40};
		cbo_pkg::cbo_mkind_t kd;
		run(8'h14, 8'h00, 8'h00, 8'h00, 1'h1, 1'h1, 1);
		chk({r.acc_we, r.acc, r.c_we, r.overflow_we}, {1'h1, 8'hFF, 2'h0});
		for (int i = 0; i < 3; i++) begin
			kd = i == 0 ? cbo_pkg::MK_DIRECT : (i == 1 ? cbo_pkg::MK_REG : cbo_pkg::MK_INDIRECT);
			run(ops[i], 8'h90, 8'h33, mv[i], 1'h1, 1'h1, 1);
			chk({mrd, mr.latch, mr.kind, mr.reg_idx}, {2'h3, kd, ops[i][2:0]});
			chk({mw.wr, mw.wdata, r.c_we, r.acc_we}, {1'h1, mv[i] - 8'h01, 2'h0});
			if (i == 0) begin
				chk(mr.addr, 8'h90);
			end
			if (i == 2) begin
				chk(mr.ptr_idx, 1'h1);
			end
		end
	endtask

	task automatic t_div;
		logic [7:0] av[5] = '{8'hFB, 8'h07, 8'hFF, 8'h00, 8'h80};
		logic [7:0] bv[5] = '{8'h12, 8'hC8, 8'h01, 8'h05, 8'h00};
		for (int i = 0; i < 5; i++) begin
			bb = bv[i];
			run(8'h84, 8'h00, av[i], 8'h00, 1'h1, 1'h0, 4);
			if (bv[i] == 8'h00) begin
				chk({r.acc_we, r.b_we, r.c_we, r.c, r.overflow_we, r.overflow_flag}, 6'h0B);
			end else begin
				chk({r.acc_we, r.acc, r.b_we, r.b}, {1'h1, av[i] / bv[i], 1'h1, av[i] % bv[i]});
				chk({r.c_we, r.c, r.overflow_we, r.overflow_flag}, 4'hA);
			end
		end
	endtask

	////////////////////////////////////////////////
	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		rst_n = 1'h0;
		issue = '0;
		arch_in = '0;
		mem_rdata = 8'h00;
		bit_rdata = 1'h0;
		bb = 8'h00;
		b3 = 8'h00;
		failures = 0;
		n_checks = 0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'h1;
		t_compare();
		t_clear_compl();
		t_adjust();
		t_decr();
		t_div();
		stop_test();
	end

	// Hang guard, well beyond the roughly 160 cycles the tests need
	initial begin
		repeat (3000) @(posedge core_clk);
		failures++;
		stop_test();
	end
endmodule
